// ### wae_pkg.sv
package wae_pkg;
  // ===========================================================
  // register map
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_LIM = 8'h04;
  localparam logic [7:0] A_WHL = 8'h08;
  localparam logic [7:0] A_CNT = 8'h0c;
  localparam logic [7:0] A_STS = 8'h10;
  // ctrl field positions
  localparam int B_SLOPE = 0;
  localparam int B_WHEEL = 1;
  localparam int B_DRAG = 2;
  localparam int B_HIGH = 3;
  localparam int B_WIDE = 4;
  localparam int B_BEAM = 5;
  localparam int CTRL_W = 6;
  // reset values
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [31:0] LIM_RST = 32'h20_28_10_a0;
  localparam logic [7:0] WHL_RST = 8'hc8;
  // ===========================================================
  // announcement caps and scan figures
  localparam logic [7:0] HB_CAP = 8'h04;
  localparam logic [7:0] HW_CAP = 8'h04;
  localparam logic [7:0] DRAG_CAP = 8'h02;
  localparam logic [7:0] LOAD_CAP = 8'h02;
  localparam logic [5:0] SAMPLES = 6'h30;
  localparam logic [15:0] MIN_AXLES = 16'h0004;
  // ===========================================================
  // timing
  localparam int CLK_KHZ = 125000;
  localparam int GATE_MIN_MS = 3;
  localparam int GATE_MIN_CYC = GATE_MIN_MS * CLK_KHZ;
  localparam int ONT_LSB = 18;
  // linearity offsets, four on-time bins by four heat bins
  localparam logic [63:0] LIN_TAB = 64'h0001_0000_0001_4321;
  typedef logic [7:0] wae_heat_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_GAP = 3'b010,
    ST_SCAN = 3'b100
  } wae_state_t;
endpackage

// ### wae_axle_alarm.sv
module wae_axle_alarm #(
  parameter int GATE_MIN_CYC = wae_pkg::GATE_MIN_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic train_start,
  input wire logic train_end,
  input wire logic slow_train,
  input wire logic gate_near,
  input wire logic gate_far,
  input wire logic sample_tick,
  input wire wae_pkg::wae_heat_t heat_brg_l,
  input wire wae_pkg::wae_heat_t heat_brg_r,
  input wire wae_pkg::wae_heat_t heat_whl_l,
  input wire wae_pkg::wae_heat_t heat_whl_r,
  input wire logic drag_closed,
  input wire logic high_closed,
  input wire logic wide_a_closed,
  input wire logic wide_b_closed,
  output logic axle_done,
  output logic hb_abs,
  output logic hb_diff,
  output logic hb_sat,
  output logic hb_slope,
  output logic hb_announce,
  output logic hw_alarm,
  output logic hw_announce,
  output logic drag_alarm,
  output logic drag_announce,
  output logic high_alarm,
  output logic high_announce,
  output logic wide_alarm,
  output logic wide_announce,
  output logic integrity_fail,
  output logic train_valid
);
  import wae_pkg::*;

  typedef struct packed {
    wae_state_t st;
    logic [CTRL_W-1:0] ctrl;
    logic [31:0] lim;
    wae_heat_t whl;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic rdy, resp;
    logic t1_prev, t2_prev;
    logic [23:0] t1_w, t2_w;
    logic [23:0] ont;
    logic [5:0] nsamp;
    wae_heat_t pk_bl, pk_br, pk_wl, pk_wr, pk_il, pk_ir;
    logic drag_l, high_l, wide_l, prev_high, prev_wide;
    logic high_done, wide_done, high_stuck, wide_stuck;
    logic [7:0] cnt_hb, cnt_hw, cnt_drag, cnt_high, cnt_wide;
    logic [15:0] axles;
    logic o_done, o_abs, o_diff, o_sat, o_slope, o_hba, o_hw, o_hwa;
    logic o_drag, o_draga, o_high, o_higha, o_wide, o_widea, o_integ, o_valid;
  } wae_regs_t;

  wae_regs_t r_reg;
  wae_regs_t r_next;

  // ===========================================================
  // helpers
  function automatic logic [7:0] inc8(input logic [7:0] x);
    return (x == 8'hff) ? x : x + 8'h01;
  endfunction

  function automatic logic [23:0] inc24(input logic [23:0] x);
    return (x == 24'hff_ffff) ? x : x + 24'h00_0001;
  endfunction

  function automatic wae_heat_t hmax(input wae_heat_t a, input wae_heat_t b);
    return (a > b) ? a : b;
  endfunction

  // on-time bin and table offset, clamped at full scale
  function automatic wae_heat_t lin_corr(input logic [23:0] ont, input wae_heat_t raw);
    logic [1:0] bin;
    logic [3:0] ofs;
    logic [8:0] sum;
    bin = (ont[23:ONT_LSB+2] != '0) ? 2'h3 : ont[ONT_LSB +: 2];
    ofs = LIN_TAB[{bin, raw[7:6], 2'b00} +: 4];
    sum = {1'b0, raw} + {5'h00, ofs};
    return sum[8] ? 8'hff : sum[7:0];
  endfunction

  function automatic logic exceeds_by(input wae_heat_t a, input wae_heat_t b,
                                      input wae_heat_t d);
    return (a > b) && ((a - b) > d);
  endfunction

  function automatic logic slope_hit(input wae_heat_t a, input wae_heat_t b,
                                     input wae_heat_t lvl, input wae_heat_t mn);
    return (a >= lvl) && (a >= mn) && ({1'b0, a} >= {b, 1'b0});
  endfunction

  function automatic logic [31:0] rd_word(input wae_regs_t s, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      A_CTRL: d = {26'h000_0000, s.ctrl};
      A_LIM: d = s.lim;
      A_WHL: d = {24'h00_0000, s.whl};
      A_CNT: d = {s.cnt_high, s.cnt_drag, s.cnt_hw, s.cnt_hb};
      A_STS: d = {s.axles, s.cnt_wide, 4'h0, s.o_integ, s.o_valid, s.wide_stuck, s.high_stuck};
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // ===========================================================
  // next state
  always_comb begin
    logic acc, t1f, t2f, ev, fast;
    wae_heat_t cl, cr;
    wae_heat_t lim_abs, lim_dif, lim_min, lim_lvl;
    logic a_abs, a_dif, a_sat, a_slp, a_hb, a_hw, a_drg, a_hi, a_wd;
    acc = 1'b0;
    t1f = 1'b0;
    t2f = 1'b0;
    ev = 1'b0;
    fast = ~slow_train;
    lim_abs = r_reg.lim[7:0];
    lim_dif = r_reg.lim[15:8];
    lim_min = r_reg.lim[23:16];
    lim_lvl = r_reg.lim[31:24];
    cl = lin_corr(r_reg.ont, r_reg.pk_bl);
    cr = lin_corr(r_reg.ont, r_reg.pk_br);
    a_abs = 1'b0;
    a_dif = 1'b0;
    a_sat = 1'b0;
    a_slp = 1'b0;
    a_hb = 1'b0;
    a_hw = 1'b0;
    a_drg = 1'b0;
    a_hi = 1'b0;
    a_wd = 1'b0;
    r_next = r_reg;
    r_next.o_done = 1'b0;

    // bus slave: zero wait, word registers, unmapped reads zero
    acc = hsel & htrans[1] & hready;
    r_next.wr_pend = acc & hwrite;
    r_next.wr_addr = haddr[7:0];
    if (acc && !hwrite && haddr[31:8] == 24'h00_0000) begin
      r_next.rdata = rd_word(r_reg, haddr[7:0]);
    end else if (acc) begin
      r_next.rdata = 32'h0000_0000;
    end
    if (r_reg.wr_pend) begin
      unique case (r_reg.wr_addr)
        A_CTRL: r_next.ctrl = hwdata[CTRL_W-1:0];
        A_LIM: r_next.lim = hwdata;
        A_WHL: r_next.whl = hwdata[7:0];
        default: ;
      endcase
    end

    // gate pulse width and qualified falling edges
    t1f = r_reg.t1_prev & ~gate_near & (r_reg.t1_w >= 24'(GATE_MIN_CYC));
    t2f = r_reg.t2_prev & ~gate_far & (r_reg.t2_w >= 24'(GATE_MIN_CYC));
    r_next.t1_prev = gate_near;
    r_next.t2_prev = gate_far;
    r_next.t1_w = gate_near ? inc24(r_reg.t1_w) : 24'h00_0000;
    r_next.t2_w = gate_far ? inc24(r_reg.t2_w) : 24'h00_0000;

    // train sequencing
    if (train_start) begin
      r_next.st = ST_GAP;
      r_next.cnt_hb = 8'h00;
      r_next.cnt_hw = 8'h00;
      r_next.cnt_drag = 8'h00;
      r_next.cnt_high = 8'h00;
      r_next.cnt_wide = 8'h00;
      r_next.axles = 16'h0000;
      r_next.prev_high = 1'b0;
      r_next.prev_wide = 1'b0;
      r_next.high_done = 1'b0;
      r_next.wide_done = 1'b0;
      r_next.pk_il = 8'h00;
      r_next.pk_ir = 8'h00;
      r_next.o_valid = 1'b0;
      r_next.high_stuck = r_reg.ctrl[B_HIGH] & ~high_closed;
      r_next.wide_stuck = r_reg.ctrl[B_WIDE] & ~(wide_a_closed & wide_b_closed);
      r_next.o_integ = (r_reg.ctrl[B_HIGH] & ~high_closed)
                     | (r_reg.ctrl[B_WIDE] & ~(wide_a_closed & wide_b_closed));
    end else if (train_end) begin
      r_next.st = ST_IDLE;
    end else begin
      unique case (r_reg.st)
        ST_IDLE: ;
        ST_GAP: begin
          // interaxle peak held for the saturation check
          r_next.pk_il = hmax(r_reg.pk_il, heat_brg_l);
          r_next.pk_ir = hmax(r_reg.pk_ir, heat_brg_r);
          if (t1f) begin
            r_next.st = ST_SCAN;
            r_next.ont = 24'h00_0000;
            r_next.nsamp = 6'h00;
            r_next.pk_bl = 8'h00;
            r_next.pk_br = 8'h00;
            r_next.pk_wl = 8'h00;
            r_next.pk_wr = 8'h00;
            r_next.drag_l = 1'b0;
            r_next.high_l = 1'b0;
            r_next.wide_l = 1'b0;
          end
        end
        ST_SCAN: begin
          r_next.ont = inc24(r_reg.ont);
          // peak hold over the half-inch samples, bearing and wheel alike
          if (sample_tick && r_reg.nsamp < SAMPLES) begin
            r_next.nsamp = r_reg.nsamp + 6'h01;
            r_next.pk_bl = hmax(r_reg.pk_bl, heat_brg_l);
            r_next.pk_br = hmax(r_reg.pk_br, heat_brg_r);
            r_next.pk_wl = hmax(r_reg.pk_wl, heat_whl_l);
            r_next.pk_wr = hmax(r_reg.pk_wr, heat_whl_r);
          end
          // open contact latched as alarm for this axle
          r_next.drag_l = r_reg.drag_l | ~drag_closed;
          r_next.high_l = r_reg.high_l | ~high_closed;
          r_next.wide_l = r_reg.wide_l | ~wide_a_closed | ~wide_b_closed;
          if (t2f) begin
            ev = 1'b1;
            r_next.st = ST_GAP;
            r_next.pk_il = 8'h00;
            r_next.pk_ir = 8'h00;
          end
        end
        default: r_next.st = ST_IDLE;
      endcase
    end

    // per-axle evaluation at the closing edge
    if (ev) begin
      a_abs = (cl > lim_abs) | (cr > lim_abs);
      a_dif = fast & (exceeds_by(cl, cr, lim_dif) | exceeds_by(cr, cl, lim_dif));
      a_sat = fast & ~(a_abs | a_dif)
            & ((lin_corr(r_reg.ont, r_reg.pk_il) > lim_abs)
            | (lin_corr(r_reg.ont, r_reg.pk_ir) > lim_abs));
      a_slp = fast & r_reg.ctrl[B_SLOPE] & ~(a_abs | a_dif)
            & (slope_hit(cl, cr, lim_lvl, lim_min)
            | slope_hit(cr, cl, lim_lvl, lim_min));
      a_hb = a_abs | a_dif | a_sat | a_slp;
      a_hw = r_reg.ctrl[B_WHEEL]
           & ((lin_corr(r_reg.ont, r_reg.pk_wl) > r_reg.whl)
           | (lin_corr(r_reg.ont, r_reg.pk_wr) > r_reg.whl));
      a_drg = r_reg.ctrl[B_DRAG] & r_reg.drag_l;
      a_hi = r_reg.ctrl[B_HIGH] & ~r_reg.high_stuck & r_reg.high_l
           & (r_reg.ctrl[B_BEAM] ? ~r_reg.prev_high : ~r_reg.high_done);
      a_wd = r_reg.ctrl[B_WIDE] & ~r_reg.wide_stuck & r_reg.wide_l
           & (r_reg.ctrl[B_BEAM] ? ~r_reg.prev_wide : ~r_reg.wide_done);
      r_next.o_done = 1'b1;
      r_next.o_abs = a_abs;
      r_next.o_diff = a_dif;
      r_next.o_sat = a_sat;
      r_next.o_slope = a_slp;
      // caps filled in passage order
      r_next.o_hba = a_hb & (r_reg.cnt_hb < HB_CAP);
      r_next.o_hw = a_hw;
      r_next.o_hwa = a_hw & (r_reg.cnt_hw < HW_CAP);
      r_next.o_drag = a_drg;
      r_next.o_draga = a_drg & (r_reg.cnt_drag < DRAG_CAP);
      r_next.o_high = a_hi;
      r_next.o_higha = a_hi & (r_reg.cnt_high < LOAD_CAP);
      r_next.o_wide = a_wd;
      r_next.o_widea = a_wd & (r_reg.cnt_wide < LOAD_CAP);
      if (a_hb) r_next.cnt_hb = inc8(r_reg.cnt_hb);
      if (a_hw) r_next.cnt_hw = inc8(r_reg.cnt_hw);
      if (a_drg) r_next.cnt_drag = inc8(r_reg.cnt_drag);
      if (a_hi) r_next.cnt_high = inc8(r_reg.cnt_high);
      if (a_wd) r_next.cnt_wide = inc8(r_reg.cnt_wide);
      r_next.prev_high = a_hi;
      r_next.prev_wide = a_wd;
      r_next.high_done = r_reg.high_done | a_hi;
      r_next.wide_done = r_reg.wide_done | a_wd;
      r_next.axles = (r_reg.axles == 16'hffff) ? r_reg.axles : r_reg.axles + 16'h0001;
      r_next.o_valid = r_reg.o_valid | (r_reg.axles + 16'h0001 >= MIN_AXLES);
    end
  end

  // ===========================================================
  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
      r_reg.st <= ST_IDLE;
      r_reg.ctrl <= CTRL_RST;
      r_reg.lim <= LIM_RST;
      r_reg.whl <= WHL_RST;
      r_reg.rdy <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state flops
  assign hreadyout = r_reg.rdy;
  assign hresp = r_reg.resp;
  assign hrdata = r_reg.rdata;
  assign axle_done = r_reg.o_done;
  assign hb_abs = r_reg.o_abs;
  assign hb_diff = r_reg.o_diff;
  assign hb_sat = r_reg.o_sat;
  assign hb_slope = r_reg.o_slope;
  assign hb_announce = r_reg.o_hba;
  assign hw_alarm = r_reg.o_hw;
  assign hw_announce = r_reg.o_hwa;
  assign drag_alarm = r_reg.o_drag;
  assign drag_announce = r_reg.o_draga;
  assign high_alarm = r_reg.o_high;
  assign high_announce = r_reg.o_higha;
  assign wide_alarm = r_reg.o_wide;
  assign wide_announce = r_reg.o_widea;
  assign integrity_fail = r_reg.o_integ;
  assign train_valid = r_reg.o_valid;

  // ===========================================================
  // checks
  a_hb_cap: assert property (@(posedge hclk) disable iff (!hresetn)
    axle_done && hb_announce |-> (hb_abs || hb_diff || hb_sat || hb_slope)
      && $past(r_reg.cnt_hb) < HB_CAP && r_reg.cnt_hb == $past(r_reg.cnt_hb) + 8'h01)
    else $error("hot-bearing announcement over cap");
  a_sat_excl: assert property (@(posedge hclk) disable iff (!hresetn)
    hb_sat |-> !hb_abs && !hb_diff)
    else $error("saturation raised beside abs or diff");
  a_slow_skip: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(axle_done) && $past(slow_train) |-> !hb_diff && !hb_sat && !hb_slope)
    else $error("slow train checked beyond absolute");
  a_slope_en: assert property (@(posedge hclk) disable iff (!hresetn)
    axle_done && hb_slope |-> $past(r_reg.ctrl[B_SLOPE]) && !hb_abs && !hb_diff)
    else $error("slope alarm while disabled");
  a_hw_cap: assert property (@(posedge hclk) disable iff (!hresetn)
    axle_done && hw_announce |-> hw_alarm && $past(r_reg.cnt_hw) < HW_CAP)
    else $error("hot-wheel announcement over cap");
  a_drag_cap: assert property (@(posedge hclk) disable iff (!hresetn)
    axle_done && drag_announce |-> drag_alarm && $past(r_reg.cnt_drag) < DRAG_CAP)
    else $error("dragging announcement over cap");
  a_beam_gap: assert property (@(posedge hclk) disable iff (!hresetn)
    axle_done && high_alarm && r_reg.ctrl[B_BEAM] |-> !$past(r_reg.prev_high))
    else $error("high load on consecutive axles");
  a_stuck_high: assert property (@(posedge hclk) disable iff (!hresetn)
    r_reg.high_stuck |-> !(axle_done && high_alarm))
    else $error("high load flagged while stuck");
  a_samp_max: assert property (@(posedge hclk) disable iff (!hresetn)
    r_reg.nsamp == SAMPLES |=> r_reg.nsamp == SAMPLES || $past(r_reg.st) != ST_SCAN
      || r_reg.st != ST_SCAN)
    else $error("sample count beyond 48");
endmodule

// ### wae_scan_model.sv
module wae_scan_model (
  input wire logic hclk,
  output logic gate_near,
  output logic gate_far,
  output logic sample_tick,
  output logic [7:0] heat_l,
  output logic [7:0] heat_r,
  output logic [7:0] whl_l,
  output logic [7:0] whl_r,
  output logic [3:0] closed
);
  timeunit 1ns;
  timeprecision 1ps;
  // ===========================================================
  // idle track: no gating, ambient heat, contacts closed
  initial begin
    {gate_near, gate_far, sample_tick} = 3'b000;
    {heat_l, heat_r, whl_l, whl_r} = 32'h0;
    closed = 4'hf;
  end
  // reading per tick: peak at tick 40, junk past the 48th
  function automatic logic [7:0] smp(input logic [7:0] p, input int k);
    if (k > 48) begin
      return 8'hff;
    end
    return (k == 40) ? p : {1'b0, p[7:1]};
  endfunction
  task automatic heat(input logic [7:0] l, r, wl, wr);
    heat_l <= l;
    heat_r <= r;
    whl_l <= wl;
    whl_r <= wr;
  endtask
  // gating pulse of n cycles, then two quiet cycles
  task automatic gate(input logic far, input int n);
    if (far) begin
      gate_far <= 1'b1;
    end else begin
      gate_near <= 1'b1;
    end
    repeat (n) @(posedge hclk);
    gate_far <= 1'b0;
    gate_near <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask
  // ===========================================================
  // one axle: gap heat, glitches, 50 ticks, close
  task automatic axle(input logic [7:0] l, r, wl, wr, g, input logic [3:0] c);
    closed <= c;
    heat(g, g, 8'h00, 8'h00);
    repeat (3) @(posedge hclk);
    heat(8'h00, 8'h00, 8'h00, 8'h00);
    gate(1'b0, 2);
    gate(1'b0, 5);
    for (int k = 1; k <= 50; k++) begin
      heat(smp(l, k), smp(r, k), smp(wl, k), smp(wr, k));
      sample_tick <= 1'b1;
      @(posedge hclk);
      sample_tick <= 1'b0;
      @(posedge hclk);
      if (k == 10) begin
        gate(1'b1, 2);
      end
    end
    heat(8'h00, 8'h00, 8'h00, 8'h00);
    gate(1'b1, 5);
  endtask
endmodule

// ### testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import wae_pkg::*;
  // ===========================================================
  // signals and scoreboard state
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic train_start = 1'b0;
  logic train_end = 1'b0;
  logic slow_train = 1'b0;
  logic hreadyout, axle_done, integrity_fail, train_valid, gate_near, gate_far, sample_tick;
  logic [7:0] bl, br, wl, wr;
  logic [3:0] cl;
  logic [12:0] res, e;
  logic [31:0] hrdata;
  logic hresp;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int hb_n, hw_n, dr_n, hi_n, wi_n, ax_n;
  logic hi_prev, wi_prev, hi_stk, wi_stk;
  logic slow = 1'b0;
  logic rd_ph = 1'b0;
  logic [5:0] ctrl = 6'h00;
  logic [31:0] lim = LIM_RST;
  logic [31:0] seed = 32'h4e35;
  logic [31:0] rq[$];
  logic [12:0] aq[$];

  wae_axle_alarm #(.GATE_MIN_CYC(4)) i_wae_axle_alarm (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .train_start(train_start),
    .train_end(train_end), .slow_train(slow_train), .gate_near(gate_near),
    .gate_far(gate_far), .sample_tick(sample_tick), .heat_brg_l(bl), .heat_brg_r(br),
    .heat_whl_l(wl), .heat_whl_r(wr), .drag_closed(cl[0]), .high_closed(cl[1]),
    .wide_a_closed(cl[2]), .wide_b_closed(cl[3]), .axle_done(axle_done),
    .hb_abs(res[12]), .hb_diff(res[11]), .hb_sat(res[10]), .hb_slope(res[9]),
    .hb_announce(res[8]), .hw_alarm(res[7]), .hw_announce(res[6]),
    .drag_alarm(res[5]), .drag_announce(res[4]), .high_alarm(res[3]),
    .high_announce(res[2]), .wide_alarm(res[1]), .wide_announce(res[0]),
    .integrity_fail(integrity_fail), .train_valid(train_valid));
  wae_scan_model i_wae_scan_model (.hclk(hclk), .gate_near(gate_near), .gate_far(gate_far),
    .sample_tick(sample_tick), .heat_l(bl), .heat_r(br), .whl_l(wl), .whl_r(wr), .closed(cl));

  initial begin
    forever #4 hclk = ~hclk;
  end
  // ===========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // correction for on-times in the lowest bin
  function automatic logic [8:0] corr(input logic [7:0] x);
    logic [8:0] s;
    s = {1'b0, x} + {5'h00, LIN_TAB[4 * int'(x[7:6]) +: 4]};
    return (s > 9'h0ff) ? 9'h0ff : s;
  endfunction
  function automatic logic slp(input logic [8:0] a, input logic [8:0] b);
    return a >= {1'b0, lim[31:24]} && a >= {1'b0, lim[23:16]} && a >= {b[7:0], 1'b0};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wait_rdy;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
    end
  endtask
  // single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rq.push_back(x);
    bus(1'b0, a, 32'h0);
  endtask
  // ===========================================================
  // train control and per-axle expectations
  task automatic start(input logic [5:0] cf, input logic [3:0] c);
    bus(1'b1, A_CTRL, {26'h0, cf});
    ctrl = cf;
    i_wae_scan_model.closed <= c;
    @(posedge hclk);
    train_start <= 1'b1;
    @(posedge hclk);
    train_start <= 1'b0;
    hi_stk = cf[B_HIGH] && !c[1];
    wi_stk = cf[B_WIDE] && !(c[2] && c[3]);
    {hb_n, hw_n, dr_n, hi_n, wi_n, ax_n} = '0;
    {hi_prev, wi_prev} = 2'b00;
  endtask
  task automatic stop(input string nm);
    rd(A_CNT, {hi_n[7:0], dr_n[7:0], hw_n[7:0], hb_n[7:0]});
    rd(A_STS, {ax_n[15:0], wi_n[7:0], 4'h0, hi_stk | wi_stk, ax_n >= 4, wi_stk, hi_stk});
    check("flags", {30'h0, integrity_fail, train_valid}, {30'h0, hi_stk | wi_stk, ax_n >= 4});
    check("axles pending", aq.size(), 32'h0);
    train_end <= 1'b1;
    @(posedge hclk);
    train_end <= 1'b0;
    $display("test done: %s", nm);
  endtask
  task automatic axle(input logic [7:0] l, r, wv, wu, g, input logic [3:0] c);
    logic [8:0] a, b, d;
    logic ab, df, st, sl, hb, hw, dg, hi, wi;
    a = corr(l);
    b = corr(r);
    d = {1'b0, lim[15:8]};
    ab = a > {1'b0, lim[7:0]} || b > {1'b0, lim[7:0]};
    df = !slow && (a > b + d || b > a + d);
    st = !slow && !ab && !df && corr(g) > {1'b0, lim[7:0]};
    sl = ctrl[B_SLOPE] && !slow && !ab && !df && (slp(a, b) || slp(b, a));
    hb = ab || df || st || sl;
    hw = ctrl[B_WHEEL] && (corr(wv) > {1'b0, WHL_RST} || corr(wu) > {1'b0, WHL_RST});
    dg = ctrl[B_DRAG] && !c[0];
    hi = ctrl[B_HIGH] && !hi_stk && !c[1] && (ctrl[B_BEAM] ? !hi_prev : hi_n == 0);
    wi = ctrl[B_WIDE] && !wi_stk && !(c[2] && c[3]) && (ctrl[B_BEAM] ? !wi_prev : wi_n == 0);
    aq.push_back({ab, df, st, sl, hb && hb_n < 4, hw, hw && hw_n < 4, dg, dg && dr_n < 2,
                  hi, hi && hi_n < 2, wi, wi && wi_n < 2});
    hb_n += int'(hb);
    hw_n += int'(hw);
    dr_n += int'(dg);
    hi_n += int'(hi);
    wi_n += int'(wi);
    ax_n++;
    {hi_prev, wi_prev} = {hi, wi};
    slow_train <= slow;
    i_wae_scan_model.axle(l, r, wv, wu, g, c);
  endtask
  // table entry: bearing l/r, wheel l/r, gap heat, contacts, slow
  task automatic run(input string nm, input logic [5:0] cf, input logic [3:0] c0,
                     input logic [47:0] t[$]);
    start(cf, c0);
    foreach (t[i]) begin
      slow = t[i][0];
      axle(t[i][47:40], t[i][39:32], t[i][31:24], t[i][23:16], t[i][15:8], t[i][7:4]);
    end
    stop(nm);
  endtask
  // ===========================================================
  // monitors: read data in data phase, axle results on axle_done
  always @(posedge hclk) begin
    if (rd_ph && hreadyout) begin
      check("hrdata", hrdata, rq.pop_front());
      check("hresp", {31'h0, hresp}, 32'h0);
    end
    if (hreadyout) begin
      rd_ph <= hsel && htrans[1] && !hwrite;
    end
  end
  always @(posedge hclk) begin
    if (axle_done === 1'b1) begin
      e = aq.pop_front();
      check("bearing", {27'h0, res[12:8]}, {27'h0, e[12:8]});
      check("wheel", {30'h0, res[7:6]}, {30'h0, e[7:6]});
      check("drag", {30'h0, res[5:4]}, {30'h0, e[5:4]});
      check("high", {30'h0, res[3:2]}, {30'h0, e[3:2]});
      check("wide", {30'h0, res[1:0]}, {30'h0, e[1:0]});
    end
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  // ===========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(A_CTRL, {26'h0, CTRL_RST});
    rd(A_LIM, LIM_RST);
    rd(A_WHL, {24'h0, WHL_RST});
    bus(1'b1, A_CNT, 32'hffff_ffff);
    bus(1'b1, 8'h14, 32'h5a5a_5a5a);
    rd(A_CNT, 32'h0);
    rd(8'h14, 32'h0);
    $display("test done: registers");
    // all enable bits off, so only absolute, differential and saturation run; cold axles see junk after the 48th tick
    run("hot bearing cap", 6'h00, 4'h0, '{48'hb0b0_d0d0_0000, 48'h2020_d0d0_0000,
        48'hb0b0_d0d0_0000, 48'h20b0_d0d0_0000, 48'hb0b0_d0d0_0000,
        48'hb0b0_d0d0_0000, 48'hb020_d0d0_0000});
    bus(1'b1, A_LIM, 32'h2028_40a0);
    lim = 32'h2028_40a0;
    rd(A_LIM, lim);
    // differential, slow, slope, saturation, wheel and contacts in trip-wire mode
    run("trip-wire mix", 6'h1f, 4'hf, '{48'h9020_0000_00f0, 48'hb020_0000_00f1,
        48'h3010_0000_00f1, 48'h3010_0000_00f0, 48'h1010_0000_f0f0,
        48'h1010_0000_f0f1, 48'h2020_d000_0080, 48'h2020_00d0_0040,
        48'h2020_0000_00e0});
    // light-beam spacing with random heat
    start(6'h3c, 4'hf);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      axle({2'b00, seed[5:0]}, {2'b00, seed[13:8]}, seed[23:16], seed[31:24], 8'h00,
           (i == 5) ? 4'hf : (i == 2) ? 4'h5 : 4'h9);
    end
    stop("light-beam spacing");
    // contacts open before the train
    run("stuck high", 6'h18, 4'hd, '{48'h2020_0000_00d0, 48'h2020_0000_0090});
    run("stuck wide", 6'h38, 4'h7, '{48'h2020_0000_0050, 48'h2020_0000_0050});
    finish_test();
  end
endmodule
